// ==== hdl/fer_error_report.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fer_defs.svh"

// Function
// - Healthy with power stage off, LED blinks one second lit, one second dark.
// - Station address must be 1 to 127 and unique on the network.
// - Failed parameter job answers with a 32-bit error code in bytes five to eight.
// - Invalid or unknown job identifier reports 0504 0001.
// - Write to read-only object is refused with 0601 0002.
// - Missing index reports 0602 0000; unsupported subindex reports 0609 0011.
// - Data type not matching parameter length reports 0607 0010.
// - Out-of-range write value reports 0609 0030.
// - Drive-specific failure reports 0800 in upper half, error number below.
// - Asynchronous error interrupting motion sends a diagnostic telegram.
// - Status bit 15 is set while an error is active.
// - Internal fault sets status bit 5 and records cause bits.
// - External fault sets status bit 6 and records cause bits.
// - Controller warning sets status bit 7 and records warning bits.
// - Most recent interruption error number is held as last stop cause.
// - Diagnostic telegram carries the current last stop cause; a mode-reject telegram carries mode_err_num instead.
// - Error flag aborts motion at once, braking or power-off per class.
// - With error flag set, external-fault or warning bit is set too.
// - Unprocessable process-data movement request sends diagnostic and sets mode byte reject bit 6, not status bit 15; dropped on a same-cycle new async error.
// - Range check by type: INT16 and UINT16 limits; INT32 and UINT32 values always pass.
// - Asynchronous error shows quick-stop or fault state in status bits 0 to 3.
// - Rejected mode request leaves motion alone and sets mode byte bit 6; bit 6 stays unchanged if a new asynchronous error starts that cycle.
module fer_error_report
    import fer_pkg::*;
#(
    parameter int LED_HALF_CYC = `FER_LED_HALF_CYC
) (
    // Clock, reset, enable.
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Station address from switches.
    input  wire logic [6:0]  station_addr,
    output logic             addr_valid,
    // Parameter job request.
    input  wire logic        job_valid,
    input  wire logic [3:0]  job_identifier,
    input  wire logic [2:0]  job_len,
    input  wire logic [31:0] job_value,
    input  wire fer_obj_t    job_obj,
    input  wire logic        job_drv_err,
    input  wire logic [15:0] job_drv_num,
    // Parameter job answer.
    output logic             rsp_valid,
    output logic             rsp_error,
    output logic [31:0]      parameter_value_field,
    // Monitoring sources.
    input  wire logic [15:0] int_fault_in,
    input  wire logic [15:0] ext_fault_in,
    input  wire logic [15:0] warn_in,
    input  wire logic        fault_class_off,
    input  wire logic [15:0] stop_err_num,
    input  wire logic        err_clear,
    input  wire logic [3:0]  op_state,
    input  wire logic        power_enabled,
    // Mode request over process data.
    input  wire logic        mode_req,
    input  wire logic        mode_req_bad,
    input  wire logic [15:0] mode_err_num,
    input  wire logic [7:0]  mode_in,
    // Status outputs.
    output logic [15:0]      drive_status_word,
    output logic [7:0]       mode_status_byte,
    output logic [15:0]      internal_fault_bits,
    output logic [15:0]      external_monitor_bits,
    output logic [15:0]      warning_bits,
    output logic [15:0]      last_stop_cause,
    // Drive reaction and diagnostics.
    output logic             motion_abort,
    output logic             brake_req,
    output logic             power_off_req,
    output logic             diag_valid,
    output logic [15:0]      diag_err_num,
    output logic             status_led
);

    // ********************************************************
    // Input synchronisers for pin-level monitoring signals
    // ********************************************************
    logic [47:0] mon_s1_r;
    logic [47:0] mon_s2_r;
    logic [6:0]  addr_s1_r;
    logic [6:0]  addr_s2_r;

    // Two stages before any logic looks at pin levels.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mon_s1_r  <= 48'h0;
            mon_s2_r  <= 48'h0;
            addr_s1_r <= 7'h0;
            addr_s2_r <= 7'h0;
        end else if (ce) begin
            mon_s1_r  <= {int_fault_in, ext_fault_in, warn_in};
            mon_s2_r  <= mon_s1_r;
            addr_s1_r <= station_addr;
            addr_s2_r <= addr_s1_r;
        end
    end

    logic [15:0] int_s;
    logic [15:0] ext_s;
    logic [15:0] wrn_s;
    assign int_s = mon_s2_r[47:32];
    assign ext_s = mon_s2_r[31:16];
    assign wrn_s = mon_s2_r[15:0];

    // ********************************************************
    // Parameter job check
    // ********************************************************
    fer_chk_if chk_bus ();

    assign chk_bus.job     = job_identifier;
    assign chk_bus.len     = job_len;
    assign chk_bus.value   = job_value;
    assign chk_bus.obj     = job_obj;
    assign chk_bus.drv_err = job_drv_err;
    assign chk_bus.drv_num = job_drv_num;

    fer_job_check u_chk (
        .c (chk_bus.chk)
    );

    // ********************************************************
    // Error state, cause bits and diagnostics
    // ********************************************************
    logic        err_r,   err_nxt;
    logic [15:0] ifb_r,   ifb_nxt;
    logic [15:0] emb_r,   emb_nxt;
    logic [15:0] wb_r,    wb_nxt;
    logic [15:0] lsc_r,   lsc_nxt;
    logic        rv_r,    rv_nxt;
    logic        re_r,    re_nxt;
    logic [31:0] pv_r,    pv_nxt;
    logic        dv_r,    dv_nxt;
    logic [15:0] dn_r,    dn_nxt;
    logic        rej_r,   rej_nxt;
    logic        ab_r,    ab_nxt;
    logic        br_r,    br_nxt;
    logic        po_r,    po_nxt;
    logic        av_r,    av_nxt;
    logic        new_async;

    // Cause bits latch on entry and then freeze until the error is cleared.
    always_comb begin
        err_nxt = err_r;
        ifb_nxt = ifb_r;
        emb_nxt = emb_r;
        wb_nxt  = wb_r;
        lsc_nxt = lsc_r;
        rv_nxt  = 1'b0;
        re_nxt  = re_r;
        pv_nxt  = pv_r;
        dv_nxt  = 1'b0;
        dn_nxt  = dn_r;
        rej_nxt = rej_r;
        ab_nxt  = 1'b0;
        br_nxt  = br_r;
        po_nxt  = po_r;
        av_nxt  = (addr_s2_r >= `FER_ADDR_MIN) && (addr_s2_r <= `FER_ADDR_MAX);
        new_async = !err_r && ((|int_s) || (|ext_s));

        // Answer in the same slot, one cycle after the request.
        if (job_valid) begin
            rv_nxt = 1'b1;
            re_nxt = chk_bus.err;
            pv_nxt = chk_bus.err ? chk_bus.code : job_value;
        end

        if (err_r && err_clear) begin
            err_nxt = 1'b0;
            br_nxt  = 1'b0;
            po_nxt  = 1'b0;
        end else if (!err_r) begin
            ifb_nxt = int_s;
            emb_nxt = ext_s;
            wb_nxt  = wrn_s | ((|int_s) ? 16'h0001 : 16'h0000);
        end

        if (new_async) begin
            err_nxt = 1'b1;
            lsc_nxt = stop_err_num;
            ab_nxt  = 1'b1;
            br_nxt  = !fault_class_off;
            po_nxt  = fault_class_off;
            dv_nxt  = 1'b1;
            dn_nxt  = stop_err_num;
        end else if (mode_req && mode_req_bad) begin
            rej_nxt = 1'b1;
            dv_nxt  = 1'b1;
            dn_nxt  = mode_err_num;
        end else if (mode_req) begin
            rej_nxt = 1'b0;
        end
    end

    // Error and reply registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_r <= 1'b0;
            ifb_r <= 16'h0;
            emb_r <= 16'h0;
            wb_r  <= 16'h0;
            lsc_r <= 16'h0;
            rv_r  <= 1'b0;
            re_r  <= 1'b0;
            pv_r  <= 32'h0;
            dv_r  <= 1'b0;
            dn_r  <= 16'h0;
            rej_r <= 1'b0;
            ab_r  <= 1'b0;
            br_r  <= 1'b0;
            po_r  <= 1'b0;
            av_r  <= 1'b0;
        end else if (ce) begin
            err_r <= err_nxt;
            ifb_r <= ifb_nxt;
            emb_r <= emb_nxt;
            wb_r  <= wb_nxt;
            lsc_r <= lsc_nxt;
            rv_r  <= rv_nxt;
            re_r  <= re_nxt;
            pv_r  <= pv_nxt;
            dv_r  <= dv_nxt;
            dn_r  <= dn_nxt;
            rej_r <= rej_nxt;
            ab_r  <= ab_nxt;
            br_r  <= br_nxt;
            po_r  <= po_nxt;
            av_r  <= av_nxt;
        end
    end

    // ********************************************************
    // Status word and mode byte
    // ********************************************************
    logic [15:0] sw_r, sw_nxt;
    logic [7:0]  ms_r, ms_nxt;

    // Status word is rebuilt each cycle from the held error state.
    always_comb begin
        sw_nxt = 16'h0;
        sw_nxt[3:0] = err_r ? (po_r ? `FER_STATE_FAULT : `FER_STATE_QSTOP) : op_state;
        sw_nxt[`FER_SW_INT_FAULT] = err_r && (|ifb_r);
        sw_nxt[`FER_SW_EXT_FAULT] = err_r && (|emb_r);
        sw_nxt[`FER_SW_WARNING]   = |wb_r;
        sw_nxt[`FER_SW_ERROR]     = err_r;
        ms_nxt = mode_in;
        ms_nxt[`FER_MS_REJECT] = rej_r;
    end

    // Status registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_r <= 16'h0;
            ms_r <= 8'h0;
        end else if (ce) begin
            sw_r <= sw_nxt;
            ms_r <= ms_nxt;
        end
    end

    // ********************************************************
    // Status LED
    // ********************************************************
    logic led_w;
    logic led_r;

    fer_led_blink #(
        .HALF_CYC (LED_HALF_CYC)
    ) u_led (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .run   (!err_r && !power_enabled),
        .led   (led_w)
    );

    // LED is steady dark on error and steady lit with the power stage on, so only a dark stuck pattern marks a fault.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            led_r <= 1'b0;
        end else if (ce) begin
            led_r <= err_r ? 1'b0 : led_w;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign addr_valid            = av_r;
    assign rsp_valid             = rv_r;
    assign rsp_error             = re_r;
    assign parameter_value_field = pv_r;
    assign drive_status_word     = sw_r;
    assign mode_status_byte      = ms_r;
    assign internal_fault_bits   = ifb_r;
    assign external_monitor_bits = emb_r;
    assign warning_bits          = wb_r;
    assign last_stop_cause       = lsc_r;
    assign motion_abort          = ab_r;
    assign brake_req             = br_r;
    assign power_off_req         = po_r;
    assign diag_valid            = dv_r;
    assign diag_err_num          = dn_r;
    assign status_led            = led_r;

    // ********************************************************
    // Checks
    // ********************************************************
    a_err_bit_follows: assert property (@(posedge clk) disable iff (!rst_n)
        ce && err_r |=> drive_status_word[15] || !ce) else $error("error bit missing");
    a_diag_on_async: assert property (@(posedge clk) disable iff (!rst_n)
        ce && new_async |=> diag_valid && diag_err_num == last_stop_cause) else $error("no diagnostic");
    a_causes_stable: assert property (@(posedge clk) disable iff (!rst_n)
        err_r && ce && !err_clear |=> $stable(internal_fault_bits) && $stable(external_monitor_bits)
            && $stable(warning_bits)) else $error("cause changed");
    a_reply_slot: assert property (@(posedge clk) disable iff (!rst_n)
        ce && job_valid |=> rsp_valid) else $error("reply slot missed");
    a_abort_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        ce && new_async |=> motion_abort ##1 !motion_abort || !ce) else $error("abort wrong");
    a_mode_reject: assert property (@(posedge clk) disable iff (!rst_n)
        ce && mode_req && mode_req_bad && !new_async |=> ##1 (mode_status_byte[6] || !ce)) else $error("reject not shown");

endmodule

`default_nettype wire

// ==== include/fer_defs.svh ====
`ifndef FER_DEFS_SVH
`define FER_DEFS_SVH

// ********************************************************
// Error codes returned in the parameter value field
// ********************************************************
`define FER_ERR_JOB_ID        32'h0504_0001
`define FER_ERR_READ_ONLY     32'h0601_0002
`define FER_ERR_NO_INDEX      32'h0602_0000
`define FER_ERR_TYPE_LEN      32'h0607_0010
`define FER_ERR_NO_SUBINDEX   32'h0609_0011
`define FER_ERR_RANGE         32'h0609_0030
`define FER_ERR_DRIVE_HI      16'h0800

// ********************************************************
// Status word and mode byte bit positions
// ********************************************************
`define FER_SW_INT_FAULT      5
`define FER_SW_EXT_FAULT      6
`define FER_SW_WARNING        7
`define FER_SW_ERROR          15
`define FER_MS_REJECT         6
`define FER_STATE_QSTOP       4'h7
`define FER_STATE_FAULT       4'h9

// ********************************************************
// Value limits per data type
// ********************************************************
`define FER_INT16_MIN         32'hFFFF_8000
`define FER_INT16_MAX         32'h0000_7FFF
`define FER_UINT16_MAX        32'h0000_FFFF

// ********************************************************
// Station address range
// ********************************************************
`define FER_ADDR_MIN          7'h01
`define FER_ADDR_MAX          7'h7F

// ********************************************************
// LED timing
// ********************************************************
`define FER_CLK_HZ            40000000
`define FER_LED_HALF_MS       1000
`define FER_LED_HALF_CYC      ((`FER_CLK_HZ / 1000) * `FER_LED_HALF_MS)

`endif

// ==== include/fer_pkg.sv ====
package fer_pkg;

    // Job identifiers handled by the parameter channel.
    typedef enum logic [3:0] {
        FER_JOB_READ  = 4'h1,
        FER_JOB_WRITE = 4'h2
    } fer_job_t;

    // Data types of parameter objects.
    typedef enum logic [1:0] {
        FER_DT_INT16  = 2'h0,
        FER_DT_UINT16 = 2'h1,
        FER_DT_INT32  = 2'h2,
        FER_DT_UINT32 = 2'h3
    } fer_dtype_t;

    // Object attributes seen by the checker.
    typedef struct packed {
        logic       index_ok;
        logic       subidx_ok;
        logic       read_only;
        fer_dtype_t dtype;
    } fer_obj_t;

endpackage

// ==== include/fer_chk_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// Carries one parameter job into the checker and its verdict back.
interface fer_chk_if;
    import fer_pkg::*;
    logic [3:0]  job;
    logic [2:0]  len;
    logic [31:0] value;
    fer_obj_t    obj;
    logic        drv_err;
    logic [15:0] drv_num;
    logic        err;
    logic [31:0] code;
    modport top (output job, len, value, obj, drv_err, drv_num, input err, code);
    modport chk (input job, len, value, obj, drv_err, drv_num, output err, code);
endinterface

`default_nettype wire

// ==== hdl/fer_job_check.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fer_defs.svh"

// Decides, without state, whether a parameter job fails and with which code.
module fer_job_check
    import fer_pkg::*;
(
    // Job and verdict.
    fer_chk_if.chk c
);

    logic len_ok;
    logic in_range;

    // Byte length must suit the object's data type; range depends on type.
    always_comb begin
        len_ok   = (c.obj.dtype == FER_DT_INT16 || c.obj.dtype == FER_DT_UINT16)
                   ? (c.len == 3'd2) : (c.len == 3'd4);
        in_range = 1'b1;
        case (c.obj.dtype)
            FER_DT_INT16:  in_range = ($signed(c.value) >= $signed(`FER_INT16_MIN)) &&
                                      ($signed(c.value) <= $signed(`FER_INT16_MAX));
            FER_DT_UINT16: in_range = (c.value <= `FER_UINT16_MAX);
            default:       in_range = 1'b1;
        endcase
    end

    // Priority: job id, index, subindex, read-only, length, range, drive error.
    always_comb begin
        c.err  = 1'b1;
        c.code = 32'h0;
        if (c.job != FER_JOB_READ && c.job != FER_JOB_WRITE)
            c.code = `FER_ERR_JOB_ID;
        else if (!c.obj.index_ok)
            c.code = `FER_ERR_NO_INDEX;
        else if (!c.obj.subidx_ok)
            c.code = `FER_ERR_NO_SUBINDEX;
        else if (c.job == FER_JOB_WRITE && c.obj.read_only)
            c.code = `FER_ERR_READ_ONLY;
        else if (c.job == FER_JOB_WRITE && !len_ok)
            c.code = `FER_ERR_TYPE_LEN;
        else if (c.job == FER_JOB_WRITE && !in_range)
            c.code = `FER_ERR_RANGE;
        else if (c.drv_err)
            c.code = {`FER_ERR_DRIVE_HI, c.drv_num};
        else
            c.err = 1'b0;
    end

endmodule

`default_nettype wire

// ==== hdl/fer_led_blink.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fer_defs.svh"

// Square wave for the status LED, one half period lit and one dark.
module fer_led_blink #(
    parameter int HALF_CYC = `FER_LED_HALF_CYC
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // Control.
    input  wire logic run,
    output logic      led
);

    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic        led_r;
    logic        led_nxt;

    // Restart lit whenever blinking is not wanted, so the pattern is phase clean.
    always_comb begin
        cnt_nxt = cnt_r;
        led_nxt = led_r;
        if (!run) begin
            cnt_nxt = 32'h0;
            led_nxt = 1'b1;
        end else if (cnt_r == 32'(HALF_CYC - 1)) begin
            cnt_nxt = 32'h0;
            led_nxt = ~led_r;
        end else begin
            cnt_nxt = cnt_r + 32'h1;
        end
    end

    // State registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 32'h0;
            led_r <= 1'b1;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            led_r <= led_nxt;
        end
    end

    assign led = led_r;

endmodule

`default_nettype wire

// ==== bench/fer_master.sv ====
`timescale 1ns/1ps
`default_nettype none

// ************************************
// Bus master model for parameter jobs
// ************************************
module fer_master
    import fer_pkg::*;
(
    // Clock.
    input  wire logic        clk,
    // Job request.
    output logic             job_valid,
    output logic [3:0]       job_identifier,
    output logic [2:0]       job_len,
    output logic [31:0]      job_value,
    output fer_obj_t         job_obj,
    output logic             job_drv_err,
    output logic [15:0]      job_drv_num,
    // Diagnostics seen by the master.
    input  wire logic        diag_valid,
    input  wire logic [15:0] diag_err_num,
    output logic [15:0]      seen_diag
);
    initial begin
        job_valid = 1'b0;
        {job_identifier, job_len, job_value, job_obj, job_drv_err, job_drv_num} = '0;
        seen_diag = 16'h0000;
    end

    // One job per call; fields are scrambled after the taking edge so stale values never look valid.
    task automatic send(input logic [3:0] id, input logic [2:0] ln, input logic [31:0] v,
                        input fer_obj_t ob, input logic de, input logic [15:0] dn);
        @(negedge clk);
        job_identifier = id;
        job_len = ln;
        job_value = v;
        job_obj = ob;
        job_drv_err = de;
        job_drv_num = dn;
        job_valid = 1'b1;
        @(negedge clk);
        job_valid = 1'b0;
        {job_identifier, job_len, job_value, job_obj, job_drv_num} =
            ~{job_identifier, job_len, job_value, job_obj, job_drv_num};
        job_drv_err = 1'b0;
    endtask

    // The master keeps only the error number of the latest telegram.
    always @(posedge clk) begin
        if (diag_valid === 1'b1) begin
            seen_diag <= diag_err_num;
        end
    end
endmodule

`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fer_defs.svh"

module tb
    import fer_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic [6:0] station_addr = 7'h00;
    logic addr_valid, rsp_valid, rsp_error, job_valid, job_drv_err;
    logic [3:0] job_identifier;
    logic [2:0] job_len;
    logic [31:0] job_value, parameter_value_field;
    fer_obj_t job_obj;
    logic [15:0] job_drv_num, seen_diag;
    logic [15:0] int_fault_in = '0, ext_fault_in = '0, warn_in = '0, stop_err_num = '0, mode_err_num = '0;
    logic fault_class_off = 1'b0, err_clear = 1'b0, power_enabled = 1'b0, mode_req = 1'b0, mode_req_bad = 1'b0;
    logic [3:0] op_state = 4'h6;
    logic [7:0] mode_in = 8'h04, mode_status_byte;
    logic [15:0] drive_status_word, internal_fault_bits, external_monitor_bits, warning_bits;
    logic [15:0] last_stop_cause, diag_err_num;
    logic motion_abort, brake_req, power_off_req, diag_valid, status_led;
    int num_errors = 0, total_checks = 0, n;

    always #12.5 clk = ~clk;

    fer_error_report #(.LED_HALF_CYC(10)) DUT (
        .clk, .rst_n, .ce, .station_addr, .addr_valid, .job_valid, .job_identifier, .job_len,
        .job_value, .job_obj, .job_drv_err, .job_drv_num, .rsp_valid, .rsp_error,
        .parameter_value_field, .int_fault_in, .ext_fault_in, .warn_in, .fault_class_off,
        .stop_err_num, .err_clear, .op_state, .power_enabled, .mode_req, .mode_req_bad,
        .mode_err_num, .mode_in, .drive_status_word, .mode_status_byte, .internal_fault_bits,
        .external_monitor_bits, .warning_bits, .last_stop_cause, .motion_abort, .brake_req,
        .power_off_req, .diag_valid, .diag_err_num, .status_led);

    fer_master master (.clk, .job_valid, .job_identifier, .job_len, .job_value, .job_obj,
        .job_drv_err, .job_drv_num, .diag_valid, .diag_err_num, .seen_diag);

    // ************************************
    // Checking and closing
    // ************************************
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // A zero expected code means the job must succeed.
    task automatic job(input logic [3:0] id, input logic [2:0] ln, input logic [31:0] v,
                       input logic [4:0] ob, input logic de, input logic [31:0] exp);
        master.send(id, ln, v, fer_obj_t'(ob), de, v[15:0]);
        cmp(rsp_valid, 1);
        cmp(rsp_error, exp != 0);
        if (exp != 0) begin
            cmp(parameter_value_field, exp);
        end else begin
            cmp(parameter_value_field, v);
        end
        @(negedge clk);
        cmp(rsp_valid, 0);
    endtask

    // Bounded wait for a telegram; pins pass a two-stage synchroniser first.
    task automatic wait_diag(input logic [15:0] exp);
        n = 0;
        while (diag_valid !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        cmp(diag_valid, 1);
        cmp(diag_err_num, exp);
    endtask

    // Pins must leave the synchroniser before the clear, or the stale level re-arms the error.
    task automatic clear_err();
        repeat (3) @(negedge clk);
        err_clear = 1'b1;
        @(negedge clk);
        err_clear = 1'b0;
        repeat (3) @(negedge clk);
        cmp(drive_status_word[15], 0);
    endtask

    // Watchdog sized well above the few hundred cycles the tests need.
    initial begin
        #(25 * 4000);
        num_errors++;
        close_out();
    end

    // ************************************
    // Test sequence
    // ************************************
    initial begin
        repeat (8) @(negedge clk);
        cmp(drive_status_word, 0);
        cmp(status_led, 0);
        rst_n = 1'b1;
        station_addr = 7'h00;
        repeat (4) @(negedge clk);
        cmp(addr_valid, 0);
        station_addr = 7'h01;
        repeat (4) @(negedge clk);
        cmp(addr_valid, 1);
        station_addr = 7'h7F;
        repeat (4) @(negedge clk);
        cmp(addr_valid, 1);
        $display("test address done");

        job(4'h3, 3'h2, 32'h0, 5'b11000, 1'b0, `FER_ERR_JOB_ID);
        job(4'h1, 3'h2, 32'h0, 5'b01000, 1'b0, `FER_ERR_NO_INDEX);
        job(4'h1, 3'h2, 32'h0, 5'b10000, 1'b0, `FER_ERR_NO_SUBINDEX);
        job(4'h2, 3'h2, 32'h5, 5'b11100, 1'b0, `FER_ERR_READ_ONLY);
        job(4'h2, 3'h4, 32'h5, 5'b11000, 1'b0, `FER_ERR_TYPE_LEN);
        job(4'h2, 3'h2, 32'h8000, 5'b11000, 1'b0, `FER_ERR_RANGE);
        job(4'h2, 3'h2, 32'hFFFF_7FFF, 5'b11000, 1'b0, `FER_ERR_RANGE);
        job(4'h2, 3'h2, 32'hFFFF_8000, 5'b11000, 1'b0, 0);
        job(4'h2, 3'h2, 32'h1_0000, 5'b11001, 1'b0, `FER_ERR_RANGE);
        job(4'h2, 3'h2, 32'hFFFF, 5'b11001, 1'b0, 0);
        job(4'h2, 3'h4, 32'hFFFF_FFFF, 5'b11011, 1'b0, 0);
        job(4'h1, 3'h2, 32'h8000, 5'b11000, 1'b0, 0);
        job(4'h1, 3'h2, 32'hAB, 5'b11000, 1'b1, {`FER_ERR_DRIVE_HI, 16'h00AB});
        $display("test jobs done");

        power_enabled = 1'b1;
        stop_err_num = 16'h1234;
        ext_fault_in = 16'h0004;
        wait_diag(16'h1234);
        cmp(motion_abort, 1);
        repeat (2) @(negedge clk);
        cmp(last_stop_cause, 16'h1234);
        cmp(seen_diag, 16'h1234);
        cmp(drive_status_word & 16'h80EF, 16'h8047);
        cmp(external_monitor_bits, 16'h0004);
        cmp({brake_req, power_off_req}, 2'b10);
        cmp(status_led, 0);
        ext_fault_in = 16'h0008;
        repeat (4) @(negedge clk);
        cmp(external_monitor_bits, 16'h0004);
        ext_fault_in = 16'h0000;
        clear_err();
        $display("test external fault done");

        fault_class_off = 1'b1;
        stop_err_num = 16'h0055;
        int_fault_in = 16'h0002;
        wait_diag(16'h0055);
        repeat (2) @(negedge clk);
        cmp(drive_status_word & 16'h80EF, 16'h80A9);
        cmp(internal_fault_bits, 16'h0002);
        cmp(warning_bits, 16'h0001);
        cmp({brake_req, power_off_req}, 2'b01);
        int_fault_in = 16'h0000;
        fault_class_off = 1'b0;
        clear_err();
        warn_in = 16'h0010;
        repeat (4) @(negedge clk);
        cmp(drive_status_word[7], 1);
        cmp(warning_bits, 16'h0010);
        warn_in = 16'h0000;
        $display("test internal fault done");

        mode_err_num = 16'h0077;
        mode_req_bad = 1'b1;
        mode_req = 1'b1;
        @(negedge clk);
        mode_req = 1'b0;
        wait_diag(16'h0077);
        cmp(motion_abort, 0);
        @(negedge clk);
        cmp(mode_status_byte, 8'h44);
        mode_req_bad = 1'b0;
        mode_req = 1'b1;
        @(negedge clk);
        mode_req = 1'b0;
        repeat (3) @(negedge clk);
        cmp(mode_status_byte, 8'h04);
        $display("test mode reject done");

        // The first lit phase also spans the steady lit level, so a full dark then lit phase is timed.
        power_enabled = 1'b0;
        n = 0;
        while (status_led !== 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (status_led === 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
        end
        cmp(n, 10);
        n = 0;
        while (status_led === 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        cmp(n, 10);
        ce = 1'b0;
        repeat (25) @(negedge clk);
        cmp(status_led, 0);
        ce = 1'b1;
        $display("test led done");
        close_out();
    end
endmodule

`default_nettype wire
